/* core/card_rx_mem.sv */
// small word memory between the card data path and the apb side
`timescale 1ns/1ps
`default_nettype none
module card_rx_mem #(
  parameter int WIDTH = 32,
  parameter int DEPTH = 16
) (
  input  wire logic                     pclk,
  input  wire logic                     wr_en,
  input  wire logic [$clog2(DEPTH)-1:0] wr_addr,
  input  wire logic [WIDTH-1:0]         wr_data,
  input  wire logic [$clog2(DEPTH)-1:0] rd_addr,
  output logic      [WIDTH-1:0]         rd_data_r
);
  logic [WIDTH-1:0] mem [DEPTH];
  // registered read keeps the output off the array decode
  always_ff @(posedge pclk) begin
    if (wr_en) begin
      mem[wr_addr] <= wr_data;
    end
    rd_data_r <= mem[rd_addr];
  end
endmodule : card_rx_mem
`default_nettype wire

/* core/card_tune_host.sv */
// card host data path with flow control, delay-line tuning and end trigger
//
// The register offsets and register access over APB were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
// How it works
// R01 - with flow control on, stall the card clock instead of over or underrun; code stalls only on a full receive fifo, having no transmit path
// R02 - without flow control, bus clock must exceed 3*width/32 times card clock
// R03 - with flow control and slow bus clock, transfers finish error-free, slower
// R04 - software keeps flow control off while feedback clock samples data
// R05 - a delay line shifts the phase of the receive sampling clock
// R06 - select feedback clock as receive source, then enable delay line
// R07 - tuning sweep starts at phase zero with feedback clock selected
// R08 - calibrate line to one clock period before applying the phase
// R09 - tuning receives a 64-byte block and checks its crc
// R10 - clean tuning block keeps current phase and delay line on; a later start taken in IDLE clears cal_r, so a plain transfer gets delay_phase_sel 0
// R11 - on crc error try next phase; after 0..12 fail, restore input
// R12 - a successful end-of-data pulse is offered as a dma trigger
// R13 - all configuration registers are plain apb writes, usable by dma
// R14 - partition access chosen by card switch commands, software side
// R15 - wait ready, erase, write boot code, wait ready, software side
// R16 - boot acknowledge enabled by switch command, software side
// R17 - boot partition chosen by switch command, software side
// R18 - boot bus width set by switch command, software side
// R19 - boot speed set by switch command, software side
// R20 - bus configuration retention set by switch command, software side
// R21 - during tuning a data timeout counts as a failed attempt
module card_tune_host #(
  parameter int TOUT_CYCLES = card_tune_pkg::TOUT_CYC,
  parameter int MEM_DEPTH   = 16
) (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        card_clock_return_input,
  input  wire logic        delay_feedback_clock,
  input  wire logic        card_data_lines,
  input  wire logic        rx_crc_ok,
  output logic             card_bus_clock_run,
  output logic             data_end_trigger,
  output logic      [3:0]  delay_phase_sel,
  output logic             delay_line_en
);
  localparam int AW = $clog2(MEM_DEPTH);
  typedef enum logic [2:0] {IDLE, CAL, RECV, CHECK, DONE} state_type;
  state_type st_r;
  logic [31:0] ctrl_r;
  logic [15:0] xfer_len_r;
  logic [3:0]  phase_r;
  logic        dly_en_r, rxsel_r;
  logic        end_r, crc_r, tout_r, cal_r, tfail_r;
  logic [2:0]  sync_r;
  logic [31:0] shift_r;
  logic [4:0]  bit_r;
  logic [15:0] bytes_r;
  logic [AW:0]   wr_ptr_r, rd_ptr_r;
  logic [15:0] cnt_r;
  logic [31:0] tmo_r;
  logic [2:0]  cal_cnt_r;
  logic        trig_r;
  logic [31:0] mem_q;
  logic        edge_rise, fifo_full, fifo_empty, wr_word, rd_word;
  logic        wr_acc, rd_acc, tuning;
  logic        start_w;
  // selected receive clock, before the three-stage sampling
  logic rx_clk_sel;
  assign rx_clk_sel = rxsel_r ? delay_feedback_clock : card_clock_return_input;

  function automatic logic hit(input logic [7:0] a, input logic [7:0] o);
    hit = (a == o);
  endfunction : hit

  ////////////////////////////////////////////////////////////////////////
  // apb slave: zero-wait answer, unmapped addresses give pslverr
  assign pready = 1'b1;
  assign wr_acc = psel && penable && pwrite;
  assign rd_acc = psel && penable && !pwrite;
  assign tuning = ctrl_r[card_tune_pkg::CTRL_TUNE_BIT];
  assign start_w = wr_acc && hit(paddr, card_tune_pkg::CTRL_OFF)
                   && pwdata[card_tune_pkg::CTRL_START_BIT];
  always_comb begin
    pslverr = 1'b0;
    prdata  = 32'h0000_0000;
    if (hit(paddr, card_tune_pkg::CTRL_OFF)) begin
      prdata = ctrl_r;
    end else if (hit(paddr, card_tune_pkg::STATUS_OFF)) begin
      prdata = {25'h0, tfail_r, fifo_full, cal_r, tout_r, crc_r, end_r,
                (st_r != IDLE)};
    end else if (hit(paddr, card_tune_pkg::DELAY_OFF)) begin
      prdata = {26'h0, rxsel_r, dly_en_r, phase_r};
    end else if (hit(paddr, card_tune_pkg::XFER_OFF)) begin
      prdata = {16'h0, xfer_len_r};
    end else if (hit(paddr, card_tune_pkg::DATA_OFF)) begin
      prdata = mem_q;
    end else if (hit(paddr, card_tune_pkg::COUNT_OFF)) begin
      prdata = {16'h0, bytes_r};
    end else begin
      pslverr = psel && penable;
    end
  end
  assign rd_word = rd_acc && hit(paddr, card_tune_pkg::DATA_OFF)
                   && !fifo_empty;

  // configuration writes, plain single-word so a dma list can program them
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_r     <= card_tune_pkg::CTRL_RST;
      xfer_len_r <= 16'h0000;
    end else if (wr_acc) begin // R13
      if (hit(paddr, card_tune_pkg::CTRL_OFF)) begin
        ctrl_r <= pwdata & ~(32'h1 << card_tune_pkg::CTRL_START_BIT);
      end else if (hit(paddr, card_tune_pkg::XFER_OFF)) begin
        xfer_len_r <= pwdata[15:0];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // delay line control: phase, enable and receive source
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      phase_r  <= card_tune_pkg::PHASE_RST;
      dly_en_r <= 1'b0;
      rxsel_r  <= 1'b0;
    end else if (wr_acc && hit(paddr, card_tune_pkg::DELAY_OFF)) begin
      phase_r  <= pwdata[3:0];
      rxsel_r  <= pwdata[5]; // R06
      dly_en_r <= pwdata[4] && pwdata[5]; // R06
    end else if (start_w && pwdata[card_tune_pkg::CTRL_TUNE_BIT]) begin
      phase_r  <= 4'h0; // R07
      rxsel_r  <= 1'b1; // R07
      dly_en_r <= 1'b1;
    end else if (st_r == CHECK && tuning) begin
      if (crc_r || tout_r) begin
        if (phase_r == card_tune_pkg::PHASE_LAST) begin
          dly_en_r <= 1'b0; // R11
          rxsel_r  <= 1'b0; // R11
        end else begin
          phase_r <= phase_r + 4'h1; // R11
        end
      end
    end
  end
  // phase only reaches the line once calibration is done
  assign delay_phase_sel = cal_r ? phase_r : 4'h0; // R08 R05
  assign delay_line_en   = dly_en_r; // R05

  ////////////////////////////////////////////////////////////////////////
  // three-flop sampling of the chosen receive clock, edge from stages 2/3
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sync_r <= 3'b000;
    end else begin
      sync_r <= {sync_r[1:0], rx_clk_sel};
    end
  end
  assign edge_rise = sync_r[1] && !sync_r[2];
  // extra wrap bit lets all MEM_DEPTH words be used before full
  assign fifo_full  = (wr_ptr_r[AW] != rd_ptr_r[AW])
                      && (wr_ptr_r[AW-1:0] == rd_ptr_r[AW-1:0]);
  assign fifo_empty = wr_ptr_r == rd_ptr_r;
  // card clock stops rather than overrun; costs throughput only
  assign card_bus_clock_run = !(ctrl_r[card_tune_pkg::CTRL_FLOW_BIT]
                                && fifo_full); // R01 R03

  ////////////////////////////////////////////////////////////////////////
  // transfer sequencer: calibrate, receive, check, end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_r      <= IDLE;
      cal_cnt_r <= 3'h0;
      cal_r     <= 1'b0;
      cnt_r     <= 16'h0000;
      tmo_r     <= 32'h0;
      bit_r     <= 5'h0;
      shift_r   <= 32'h0;
      bytes_r   <= 16'h0000;
    end else begin
      case (st_r)
        IDLE: begin
          if (start_w) begin
            cnt_r   <= pwdata[card_tune_pkg::CTRL_TUNE_BIT]
                       ? 16'(card_tune_pkg::TUNE_BYTES) : xfer_len_r; // R09
            bytes_r <= 16'h0000;
            tmo_r   <= 32'h0;
            bit_r   <= 5'h0;
            cal_cnt_r <= 3'h0;
            cal_r   <= 1'b0;
            st_r    <= pwdata[card_tune_pkg::CTRL_TUNE_BIT] ? CAL : RECV;
          end
        end
        CAL: begin
          if (edge_rise) begin
            cal_cnt_r <= cal_cnt_r + 3'h1;
          end
          if (cal_cnt_r == 3'(card_tune_pkg::CAL_EDGES)) begin
            cal_r <= 1'b1; // R08
            st_r  <= RECV;
          end
        end
        RECV: begin
          // a clock held by flow control is not a silent card
          if (card_bus_clock_run) begin
            tmo_r <= tmo_r + 32'h1;
          end
          if (edge_rise && card_bus_clock_run) begin
            shift_r <= {shift_r[30:0], card_data_lines};
            bit_r   <= bit_r + 5'h1;
            tmo_r   <= 32'h0;
            if (bit_r[2:0] == 3'h7) begin
              bytes_r <= bytes_r + 16'h1;
              if (bytes_r + 16'h1 >= cnt_r) begin
                st_r <= CHECK;
              end
            end
          end else if (tmo_r >= 32'(TOUT_CYCLES - 1)) begin
            st_r <= CHECK; // R21
          end
        end
        CHECK: begin
          tmo_r <= 32'h0;
          // only a retry recalibrates; a kept phase stays applied until the next start clears cal_r
          if (tuning && (crc_r || tout_r)
              && phase_r != card_tune_pkg::PHASE_LAST) begin
            st_r      <= CAL;
            cal_r     <= 1'b0;
            cal_cnt_r <= 3'h0;
            bytes_r   <= 16'h0000;
            bit_r     <= 5'h0;
          end else begin
            st_r <= DONE;
          end
        end
        default: begin
          st_r <= IDLE;
        end
      endcase
    end
  end
  assign wr_word = st_r == RECV && edge_rise && card_bus_clock_run
                   && bit_r == 5'h1F && !tuning;

  // fifo pointers into the receive memory
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wr_ptr_r <= '0;
      rd_ptr_r <= '0;
    end else begin
      if (wr_word && !fifo_full) begin
        wr_ptr_r <= wr_ptr_r + (AW+1)'(1);
      end
      if (rd_word) begin
        rd_ptr_r <= rd_ptr_r + (AW+1)'(1);
      end
    end
  end
  card_rx_mem #(.WIDTH(32), .DEPTH(MEM_DEPTH)) u_mem (
    .pclk     (pclk),
    .wr_en    (wr_word && !fifo_full),
    .wr_addr  (wr_ptr_r[AW-1:0]),
    .wr_data  ({shift_r[30:0], card_data_lines}),
    .rd_addr  (rd_word ? rd_ptr_r[AW-1:0] + AW'(1) : rd_ptr_r[AW-1:0]),
    .rd_data_r(mem_q)
  );

  ////////////////////////////////////////////////////////////////////////
  // status flags: set wins over the start that clears them
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      end_r   <= 1'b0;
      crc_r   <= 1'b0;
      tout_r  <= 1'b0;
      tfail_r <= 1'b0;
      trig_r  <= 1'b0;
    end else begin
      trig_r <= 1'b0;
      if (start_w || (st_r == CHECK && tuning)) begin
        crc_r  <= 1'b0;
        tout_r <= 1'b0;
        end_r  <= 1'b0;
      end
      if (start_w) begin
        tfail_r <= 1'b0;
      end
      if (st_r == RECV && tmo_r >= 32'(TOUT_CYCLES - 1) && !edge_rise) begin
        tout_r <= 1'b1; // R21
      end
      if (st_r == RECV && edge_rise && bit_r[2:0] == 3'h7
          && bytes_r + 16'h1 >= cnt_r) begin
        crc_r <= !rx_crc_ok; // R09
        if (rx_crc_ok) begin
          end_r  <= 1'b1; // R10
          trig_r <= 1'b1; // R12
        end
      end
      if (st_r == CHECK && tuning && (crc_r || tout_r)
          && phase_r == card_tune_pkg::PHASE_LAST) begin
        tfail_r <= 1'b1; // R11
      end
    end
  end
  assign data_end_trigger = trig_r; // R12

  // trigger fires only with the end flag, one cycle after the last byte
  property p_trig_end;
    @(posedge pclk) disable iff (!presetn)
      data_end_trigger |-> end_r && st_r == CHECK;
  endproperty
  a_trig_end: assert property (p_trig_end) // R12
    else $error("end trigger without end flag");
  property p_flow_stall;
    @(posedge pclk) disable iff (!presetn)
      ctrl_r[0] && fifo_full |-> !card_bus_clock_run;
  endproperty
  a_flow_stall: assert property (p_flow_stall) // R01
    else $error("card clock runs into full fifo");
  property p_phase_cal;
    @(posedge pclk) disable iff (!presetn)
      !cal_r |-> delay_phase_sel == 4'h0;
  endproperty
  a_phase_cal: assert property (p_phase_cal) // R08
    else $error("phase applied before calibration");
  property p_restore;
    @(posedge pclk) disable iff (!presetn)
      st_r == CHECK && tuning && (crc_r || tout_r) && phase_r == 4'hC
      |=> !delay_line_en && !rxsel_r;
  endproperty
  a_restore: assert property (p_restore) // R11
    else $error("line not restored after last phase");
  property p_next_phase;
    @(posedge pclk) disable iff (!presetn)
      st_r == CHECK && tuning && crc_r && phase_r < 4'hC
      |=> phase_r == $past(phase_r) + 4'h1;
  endproperty
  a_next_phase: assert property (p_next_phase) // R11
    else $error("phase did not advance");
  property p_keep;
    @(posedge pclk) disable iff (!presetn)
      st_r == CHECK && tuning && !crc_r && !tout_r
      |=> $stable(phase_r) && delay_line_en;
  endproperty
  a_keep: assert property (p_keep) // R10
    else $error("good phase not kept");
  property p_start_zero;
    @(posedge pclk) disable iff (!presetn)
      start_w && pwdata[3] |=> phase_r == 4'h0 && rxsel_r;
  endproperty
  a_start_zero: assert property (p_start_zero) // R07
    else $error("sweep not started at phase zero");
  property p_tout;
    @(posedge pclk) disable iff (!presetn)
      st_r == RECV ##1 st_r == CHECK && !end_r |-> tout_r || crc_r;
  endproperty
  a_tout: assert property (p_tout) // R21
    else $error("attempt ended without failure flag");
endmodule : card_tune_host
`default_nettype wire

/* core/card_tune_pkg.sv */
// shared offsets, fields, reset values and timing for the card host tuning block
package card_tune_pkg;
  // apb register byte offsets
  localparam logic [7:0] CTRL_OFF   = 8'h00;
  localparam logic [7:0] STATUS_OFF = 8'h04;
  localparam logic [7:0] DELAY_OFF  = 8'h08;
  localparam logic [7:0] XFER_OFF   = 8'h0C;
  localparam logic [7:0] DATA_OFF   = 8'h10;
  localparam logic [7:0] COUNT_OFF  = 8'h14;
  // control fields
  localparam int CTRL_FLOW_BIT  = 0;
  localparam int CTRL_RXSEL_BIT = 1;
  localparam int CTRL_DLYEN_BIT = 2;
  localparam int CTRL_TUNE_BIT  = 3;
  localparam int CTRL_START_BIT = 4;
  localparam int CTRL_DIR_BIT   = 5;
  localparam int CTRL_LANE_LSB  = 8;
  // status fields
  localparam int ST_BUSY_BIT  = 0;
  localparam int ST_END_BIT   = 1;
  localparam int ST_CRC_BIT   = 2;
  localparam int ST_TOUT_BIT  = 3;
  localparam int ST_CAL_BIT   = 4;
  localparam int ST_PAUSE_BIT = 5;
  localparam int ST_TFAIL_BIT = 6;
  // reset values
  localparam logic [31:0] CTRL_RST  = 32'h0000_0000;
  localparam logic [3:0]  PHASE_RST = 4'h0;
  // tuning block and phase range
  localparam int TUNE_BYTES = 64;
  localparam logic [3:0] PHASE_LAST = 4'hC;
  // data timeout
  localparam int TOUT_US = 100;
  localparam int CLK_MHZ = 40;
  localparam int TOUT_CYC = TOUT_US * CLK_MHZ;
  // delay-line calibration time in card clock edges
  localparam int CAL_EDGES = 4;
endpackage : card_tune_pkg

/* test/card_model.sv */
// card-side model: returns the bus clock, streams serial data, gives crc
`timescale 1ns/1ps
`default_nettype none
module card_model (
  input  wire logic       active,
  input  wire logic [3:0] good_phase,
  input  wire logic       card_bus_clock_run,
  input  wire logic [3:0] delay_phase_sel,
  output logic            card_clock_return_input,
  output logic            delay_feedback_clock,
  output logic            card_data_lines,
  output logic            rx_crc_ok
);
  logic ck;
  int   k;
  ////////////////////////////////////////////////////////////////////
  // byte i of a frame is A5 xor i, sent msb first
  function automatic logic pat_bit(input int idx);
    logic [7:0] b;
    b = 8'hA5 ^ 8'(idx / 8);
    return b[7 - (idx % 8)];
  endfunction : pat_bit
  // crc is good only at the phase where the eye sits
  assign rx_crc_ok = (delay_phase_sel == good_phase);
  assign card_clock_return_input = ck;
  assign delay_feedback_clock = ck;
  // clock stands still outside frames; lines pulled up when idle
  initial begin
    ck = 1'b0;
    k = 0;
    forever begin
      if (!active) begin
        k = 0;
        card_data_lines = 1'b1;
      end else card_data_lines = pat_bit(k);
      #100;
      if (active && card_bus_clock_run) begin
        ck = 1'b1;
        #100;
        ck = 1'b0;
        k = k + 1;
      end
    end
  end
endmodule : card_model
`default_nettype wire

/* test/tb_card_tune_host.sv */
// self-checking bench for the card host tuning block
`timescale 1ns/1ps
`default_nettype none
module tb_card_tune_host;
  logic        pclk, presetn, psel, penable, pwrite, active, e;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, q;
  logic        pready, pslverr, ck_ret, fb_ck, dat, crc_ok, run, trig;
  logic        dly_en;
  logic [3:0]  ph, good_ph;
  int          bad_count = 0, tests_run = 0, ends = 0, cyc = 0, n;
  bit          paused = 1'b0;

  card_tune_host #(.TOUT_CYCLES(50)) dut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .card_clock_return_input(ck_ret),
    .delay_feedback_clock(fb_ck), .card_data_lines(dat),
    .rx_crc_ok(crc_ok), .card_bus_clock_run(run),
    .data_end_trigger(trig), .delay_phase_sel(ph), .delay_line_en(dly_en));
  card_model card (
    .active(active), .good_phase(good_ph), .card_bus_clock_run(run),
    .delay_phase_sel(ph), .card_clock_return_input(ck_ret),
    .delay_feedback_clock(fb_ck), .card_data_lines(dat),
    .rx_crc_ok(crc_ok));
  ////////////////////////////////////////////////////////////////////
  initial begin
    pclk = 1'b0;
    forever #12.5 pclk = ~pclk;
  end
  // trigger pulses, pauses, and a ceiling so a hang cannot run forever
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (trig === 1'b1) ends <= ends + 1;
    if (run === 1'b0 && presetn === 1'b1) paused <= 1'b1;
    if (cyc == 95000) begin
      bad_count++;
      close_out();
    end
  end
  task automatic close_out();
    $display("checks %0d mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : close_out
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      bad_count++;
      $display("CHECK FAILED at %0t: got %h want %h", $time, seen, exp);
    end
  endtask : chk
  // one apb transfer; an edge passes first so psel is never set twice
  task automatic apb(input logic wr_i, input logic [7:0] a,
                     input logic [31:0] d, output logic [31:0] rq,
                     output logic err);
    int   w;
    logic rdy;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr_i;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    w = 0;
    // answer is read while it stands, then taken at the next rising edge
    do begin
      @(negedge pclk);
      rdy = pready;
      rq = prdata;
      err = pslverr;
      @(posedge pclk);
      w++;
    end while (rdy !== 1'b1 && w < 100);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] x;
    logic        y;
    apb(1'b1, a, d, x, y);
  endtask : wr
  task automatic rd(input logic [7:0] a);
    apb(1'b0, a, 32'h0, q, e);
  endtask : rd
  // poll busy with a bound; the ceiling catches a stuck block
  task automatic wait_idle();
    int w;
    w = 0;
    do begin
      rd(card_tune_pkg::STATUS_OFF);
      w++;
    end while (q[card_tune_pkg::ST_BUSY_BIT] === 1'b1 && w < 40000);
  endtask : wait_idle
  function automatic logic [31:0] word(input int j);
    logic [31:0] x;
    for (int i = 0; i < 4; i++) x[31-8*i -: 8] = 8'hA5 ^ 8'(4*j+i);
    return x;
  endfunction : word
  task automatic xfer(input int nb, input logic [31:0] ctl);
    wr(card_tune_pkg::XFER_OFF, 32'(nb));
    wr(card_tune_pkg::CTRL_OFF, ctl);
    active <= 1'b1;
  endtask : xfer
  ////////////////////////////////////////////////////////////////////
  initial begin
    {presetn, psel, penable, pwrite, active} = '0;
    paddr = 8'h00;
    pwdata = 32'h0;
    good_ph = 4'h0;
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    rd(card_tune_pkg::CTRL_OFF);
    chk(q, card_tune_pkg::CTRL_RST);
    chk(32'(ph), 32'(card_tune_pkg::PHASE_RST));
    rd(8'h18);
    chk(32'(e), 32'h1);
    // enable without the feedback select must not take
    wr(card_tune_pkg::DELAY_OFF, 32'h10);
    repeat (2) @(posedge pclk);
    chk(32'(dly_en), 32'h0);
    wr(card_tune_pkg::DELAY_OFF, 32'h30);
    repeat (2) @(posedge pclk);
    chk(32'(dly_en), 32'h1);
    wr(card_tune_pkg::DELAY_OFF, 32'h00);
    // plain two-word receive
    xfer(8, 32'h10);
    wait_idle();
    active <= 1'b0;
    chk(32'(ends), 32'h1);
    rd(card_tune_pkg::COUNT_OFF);
    chk(q, 32'h8);
    for (int j = 0; j < 2; j++) begin
      rd(card_tune_pkg::DATA_OFF);
      chk(q, word(j));
    end
    // flow control: overfill the store, clock must pause, data intact
    paused <= 1'b0;
    xfer(72, 32'h11);
    n = 0;
    while (!paused && n < 20000) begin
      @(posedge pclk);
      n++;
    end
    chk(32'(paused), 32'h1);
    for (int j = 0; j < 18; j++) begin
      if (j == 16) wait_idle();
      rd(card_tune_pkg::DATA_OFF);
      chk(q, word(j));
    end
    active <= 1'b0;
    rd(card_tune_pkg::STATUS_OFF);
    chk(q & 32'h0000_000C, 32'h0);
    chk(32'(ends), 32'h2);
    // bad crc: no trigger, error flagged
    good_ph <= 4'hF;
    xfer(4, 32'h10);
    wait_idle();
    active <= 1'b0;
    chk(32'(q[card_tune_pkg::ST_CRC_BIT]), 32'h1);
    chk(32'(ends), 32'h2);
    // tuning that locks at phase three
    good_ph <= 4'h3;
    wr(card_tune_pkg::DELAY_OFF, 32'h20);
    xfer(64, 32'h18);
    wait_idle();
    active <= 1'b0;
    chk(32'(ph), 32'h3);
    chk(32'(dly_en), 32'h1);
    chk(32'(q[card_tune_pkg::ST_CAL_BIT]), 32'h1);
    chk(32'(q[card_tune_pkg::ST_TFAIL_BIT]), 32'h0);
    // tuning where every phase fails
    good_ph <= 4'hF;
    xfer(64, 32'h18);
    wait_idle();
    active <= 1'b0;
    chk(32'(q[card_tune_pkg::ST_TFAIL_BIT]), 32'h1);
    chk(32'(dly_en), 32'h0);
    rd(card_tune_pkg::DELAY_OFF);
    chk(32'(q[5]), 32'h0);
    close_out();
  end
endmodule : tb_card_tune_host
`default_nettype wire
